// >>> rtl/clock_ctrl_pkg.sv
// Summary of operation
// - Every reset loads the factory calibration byte into the trim register.
// - Trim register is software read/write; each write retunes the RC oscillator.
// - Trim bit 7 picks low or high overlapping frequency range.
// - Lower seven trim bits tune frequency monotonically, small steps.
// - Source code 0011 selects the 128 kHz internal oscillator.
// - 128 kHz source: wake 6 cycles; reset delay 14, +4 ms, +64 ms.
// - Source code 0000 selects the external clock input.
// - External clock: wake 6 cycles; reset delay 14, +4.1 ms, +65 ms.
// - Reset pin disable fuse stretches shortest delay to 14 cycles plus 4.1 ms.
// - Clock output fuse drives system clock on output pin once fuses are latched; pin is undriven in reset.
// - Clock output pin carries the divided system clock, except at division 1, where it carries half the undivided clock.
// - Timer oscillator pins usable only with an internal RC source.
// - Prescaler divides I/O, converter, CPU and flash clocks.
// - Division change is glitch free; no shorter intermediate period.
// - New division active after one old plus one or two new periods.
// - Prescaler is a counter on the undivided clock, not readable.
// - Change enable write, then division write within four cycles.
// - Change enable clears after four cycles or on division write.
// - Division select codes 0000..1000 mean divide 1..256; rest reserved.
// - Reset division is 0011 with divide-by-eight fuse, else 0000.
package clock_ctrl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] TRIM_ADDR       = 12'h000;
  localparam logic [11:0] PRESCALE_ADDR   = 12'h004;
  localparam logic [11:0] ASYNC_TIMER_ADDR = 12'h008;
  localparam logic [11:0] STATUS_ADDR     = 12'h00C;

  // ==========================================================
  // Field positions
  localparam int CHANGE_ENABLE_BIT = 7;
  localparam int TIMER_EXT_CLK_BIT = 4;
  localparam int DIV_WIDTH         = 4;

  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] TRIM_FACTORY_DEFAULT = 8'h80;
  localparam logic [3:0] DIV_RESET_BY8  = 4'h3;
  localparam logic [3:0] DIV_RESET_BY1  = 4'h0;
  localparam logic [3:0] DIV_MAX_CODE   = 4'h8;
  localparam logic [3:0] SRC_EXTERNAL   = 4'h0;
  localparam logic [3:0] SRC_RC_8M      = 4'h2;
  localparam logic [3:0] SRC_RC_128K    = 4'h3;
  localparam logic [1:0] SUT_SHORT      = 2'h0;
  localparam logic [1:0] SUT_FAST       = 2'h1;
  localparam logic [1:0] SUT_SLOW       = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 200;
  localparam int CHANGE_WINDOW    = 4;
  localparam int BASE_DELAY_CK    = 14;
  localparam int WAKE_DELAY_CK    = 6;
  localparam int DELAY_4_US       = 4000;
  localparam int DELAY_4P1_US     = 4100;
  localparam int DELAY_64_US      = 64000;
  localparam int DELAY_65_US      = 65000;
  localparam int DELAY_4_CYC      = DELAY_4_US * CLK_MHZ;
  localparam int DELAY_4P1_CYC    = DELAY_4P1_US * CLK_MHZ;
  localparam int DELAY_64_CYC     = DELAY_64_US * CLK_MHZ;
  localparam int DELAY_65_CYC     = DELAY_65_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_RESET_HOLD = 2'b00,
    ST_DELAY      = 2'b01,
    ST_RUN        = 2'b11
  } start_state_t;

endpackage : clock_ctrl_pkg

// >>> rtl/sync_two_ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff
  import clock_ctrl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne_reg;

  // ==========================================================
  // Two-flop synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stageOne_reg <= '0;
      syncOut      <= '0;
    end else begin
      stageOne_reg <= asyncIn;
      syncOut      <= stageOne_reg;
    end
  end
endmodule : sync_two_ff
`default_nettype wire

// >>> rtl/glitchless_divider.sv
`timescale 1ns/1ps
`default_nettype none
module glitchless_divider
  import clock_ctrl_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic [DIV_WIDTH-1:0] divSelect,
  output logic                      divTick,
  output logic                      divClk
);
  logic [7:0]           count_reg;
  logic [7:0]           limit;
  logic [DIV_WIDTH-1:0] active_reg;
  logic                 change;

  // Half-period count limit of the active setting
  always_comb begin
    limit = 8'h00;
    if (active_reg != 4'h0)
      limit = 8'(({8'h00, 8'h01} << active_reg) >> 1) - 8'h01;
  end

  assign change = (divSelect != active_reg);

  // ==========================================================
  // Counter on undivided clock; setting swaps only at a period end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg  <= 8'h00;
      active_reg <= DIV_RESET_BY1;
      divClk     <= 1'b0;
      divTick    <= 1'b0;
    end else begin
      divTick <= 1'b0;
      if (active_reg == 4'h0) begin
        divTick <= 1'b1;
        divClk  <= ~divClk;
        if (change)
          active_reg <= divSelect;
      end else if (count_reg >= limit) begin
        count_reg <= 8'h00;
        divClk    <= ~divClk;
        divTick   <= divClk;
        if (divClk && change)
          active_reg <= divSelect;
      end else begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end
endmodule : glitchless_divider
`default_nettype wire

// >>> rtl/clock_source_trim_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module clock_source_trim_prescaler
  import clock_ctrl_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM   = TRIM_FACTORY_DEFAULT,
  parameter int         DELAY_4_CNT    = DELAY_4_CYC,
  parameter int         DELAY_4P1_CNT  = DELAY_4P1_CYC,
  parameter int         DELAY_64_CNT   = DELAY_64_CYC,
  parameter int         DELAY_65_CNT   = DELAY_65_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  clock_source_fuses,
  input  wire logic [1:0]  startup_time_fuses,
  input  wire logic        reset_pin_disable_fuse,
  input  wire logic        clock_output_fuse,
  input  wire logic        divide_by_eight_fuse,
  input  wire logic        portPinOut,
  input  wire logic        portPinOutEnN,
  input  wire logic        timerOscRequest,
  input  wire logic        wakeRequest,
  output logic [7:0]       rc_oscillator_trim,
  output logic             sel128kOsc,
  output logic             selExternalClock,
  output logic             timerOscEnable,
  output logic             timer_external_clock_select,
  output logic             coreRunning,
  output logic             systemClockTick,
  output logic             clock_output_pin,
  output logic             clockOutputPinEnN
);

  // ==========================================================
  // Fuse synchronisers and reset capture
  logic [9:0] fuseSync;
  logic [3:0] srcFuse_reg;
  logic [1:0] sutFuse_reg;
  logic       rstDisFuse_reg;
  logic       clkOutFuse_reg;
  logic       div8Fuse_reg;
  logic       fusesTaken_reg;
  logic       wakeSync;
  logic       wakePrev_reg;
  logic [1:0] fillCount_reg;

  sync_two_ff #(.WIDTH(10)) uFuseSync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .asyncIn ({clock_source_fuses, startup_time_fuses, reset_pin_disable_fuse,
               clock_output_fuse, divide_by_eight_fuse, timerOscRequest}),
    .syncOut (fuseSync)
  );

  sync_two_ff #(.WIDTH(1)) uWakeSync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .asyncIn (wakeRequest),
    .syncOut (wakeSync)
  );

  // Synchroniser fill; fuse levels valid only after two edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      fillCount_reg <= 2'h0;
    else if (fillCount_reg != 2'h2)
      fillCount_reg <= fillCount_reg + 2'h1;
  end

  // Fuses latched once after reset release
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      srcFuse_reg    <= SRC_RC_8M;
      sutFuse_reg    <= SUT_SHORT;
      rstDisFuse_reg <= 1'b0;
      clkOutFuse_reg <= 1'b0;
      div8Fuse_reg   <= 1'b0;
      fusesTaken_reg <= 1'b0;
    end else if (!fusesTaken_reg && fillCount_reg == 2'h2) begin  // Third edge: levels settled
      srcFuse_reg    <= fuseSync[9:6];
      sutFuse_reg    <= fuseSync[5:4];
      rstDisFuse_reg <= fuseSync[3];
      clkOutFuse_reg <= fuseSync[2];
      div8Fuse_reg   <= fuseSync[1];
      fusesTaken_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Start-up delay sequencer
  start_state_t state_reg;
  logic [31:0]  delay_reg;
  logic [31:0]  delayTarget;
  logic         wakeEdge;
  logic         rcSource;

  assign rcSource = (srcFuse_reg == SRC_RC_8M) || (srcFuse_reg == SRC_RC_128K);
  assign wakeEdge = wakeSync & ~wakePrev_reg;

  // Reset delay chosen from source and start-up fuses
  always_comb begin
    delayTarget = 32'(BASE_DELAY_CK);
    case (sutFuse_reg)
      SUT_SHORT: begin
        if (rstDisFuse_reg)
          delayTarget = 32'(BASE_DELAY_CK + DELAY_4P1_CNT);
      end
      SUT_FAST: begin
        if (srcFuse_reg == SRC_RC_128K)
          delayTarget = 32'(BASE_DELAY_CK + DELAY_4_CNT);
        else
          delayTarget = 32'(BASE_DELAY_CK + DELAY_4P1_CNT);
      end
      SUT_SLOW: begin
        if (srcFuse_reg == SRC_RC_128K)
          delayTarget = 32'(BASE_DELAY_CK + DELAY_64_CNT);
        else
          delayTarget = 32'(BASE_DELAY_CK + DELAY_65_CNT);
      end
      default: delayTarget = 32'(BASE_DELAY_CK);             // Reserved code
    endcase
  end

  // Sequencer: hold, count delay, run; wake uses short delay
  // Leaves hold one edge after fuse capture, so delay uses latched codes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= ST_RESET_HOLD;
      delay_reg    <= 32'h0000_0000;
      wakePrev_reg <= 1'b0;
    end else begin
      wakePrev_reg <= wakeSync;
      case (state_reg)
        ST_RESET_HOLD: begin
          if (fusesTaken_reg) begin
            state_reg <= ST_DELAY;
            delay_reg <= delayTarget;
          end
        end
        ST_DELAY: begin
          if (delay_reg <= 32'h0000_0001)
            state_reg <= ST_RUN;
          else
            delay_reg <= delay_reg - 32'h0000_0001;
        end
        ST_RUN: begin
          if (wakeEdge) begin
            state_reg <= ST_DELAY;
            delay_reg <= 32'(WAKE_DELAY_CK);
          end
        end
        default: state_reg <= ST_RESET_HOLD;
      endcase
    end
  end

  // ==========================================================
  // Source selection and timer oscillator sharing
  // Timer oscillator stays off until fuses are latched;
  // the reset source value would otherwise pass a false enable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel128kOsc       <= 1'b0;
      selExternalClock <= 1'b0;
      timerOscEnable   <= 1'b0;
      coreRunning      <= 1'b0;
    end else begin
      sel128kOsc       <= fusesTaken_reg && srcFuse_reg == SRC_RC_128K;
      selExternalClock <= fusesTaken_reg && srcFuse_reg == SRC_EXTERNAL;
      timerOscEnable   <= fusesTaken_reg && fuseSync[0] && rcSource;
      coreRunning      <= state_reg == ST_RUN;
    end
  end

  // ==========================================================
  // AHB-Lite slave
  logic        dataPhase_reg;
  logic        dataWrite_reg;
  logic [11:0] dataAddr_reg;
  logic        addrValid;

  assign addrValid = hsel && htrans[1] && hready;

  // Address phase capture; zero wait states
  // Write lands at the end of its data phase, so a read issued
  // in that same data phase still returns the old contents
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dataPhase_reg <= 1'b0;
      dataWrite_reg <= 1'b0;
      dataAddr_reg  <= 12'h000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else begin
      dataPhase_reg <= addrValid;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      if (addrValid) begin
        dataWrite_reg <= hwrite;
        dataAddr_reg  <= haddr[11:0];
      end
    end
  end

  logic wrTrim;
  logic wrPrescale;
  logic wrAsync;
  logic rdValid;

  assign wrTrim     = dataPhase_reg && dataWrite_reg && dataAddr_reg == TRIM_ADDR;
  assign wrPrescale = dataPhase_reg && dataWrite_reg && dataAddr_reg == PRESCALE_ADDR;
  assign wrAsync    = dataPhase_reg && dataWrite_reg && dataAddr_reg == ASYNC_TIMER_ADDR;
  assign rdValid    = addrValid && !hwrite;

  // ==========================================================
  // Trim register
  // No range check: software keeps the value safe for memory writes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      rc_oscillator_trim <= FACTORY_TRIM;
    else if (wrTrim)
      rc_oscillator_trim <= hwdata[7:0];
  end

  // Timer external clock select
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      timer_external_clock_select <= 1'b0;
    else if (wrAsync)
      timer_external_clock_select <= hwdata[TIMER_EXT_CLK_BIT];
  end

  // ==========================================================
  // Prescaler control with timed unlock
  logic [DIV_WIDTH-1:0] prescale_division_select;
  logic                 prescale_change_enable;
  logic [2:0]           window_reg;
  logic                 enableWrite;
  logic                 divWrite;
  logic                 divLoaded_reg;

  assign enableWrite = wrPrescale && hwdata[CHANGE_ENABLE_BIT] && hwdata[6:0] == 7'h00;
  assign divWrite    = wrPrescale && !hwdata[CHANGE_ENABLE_BIT];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prescale_change_enable <= 1'b0;
      window_reg             <= 3'h0;
    end else if (divWrite && prescale_change_enable) begin
      prescale_change_enable <= 1'b0;
      window_reg             <= 3'h0;
    end else if (enableWrite && !prescale_change_enable) begin
      prescale_change_enable <= 1'b1;
      window_reg             <= 3'(CHANGE_WINDOW);
    end else if (prescale_change_enable) begin
      if (window_reg <= 3'h1)
        prescale_change_enable <= 1'b0;
      window_reg <= window_reg - 3'h1;
    end
  end

  // Division select, reset from fuse after capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prescale_division_select <= DIV_RESET_BY1;
      divLoaded_reg            <= 1'b0;
    end else if (!divLoaded_reg && fusesTaken_reg) begin
      prescale_division_select <= div8Fuse_reg ? DIV_RESET_BY8 : DIV_RESET_BY1;
      divLoaded_reg            <= 1'b1;
    end else if (divWrite && prescale_change_enable) begin
      prescale_division_select <= hwdata[DIV_WIDTH-1:0];
    end
  end

  // Reserved codes clamp to largest division
  // Clamp keeps the divider from an undefined half-period count
  logic [DIV_WIDTH-1:0] effDiv;
  assign effDiv = (prescale_division_select > DIV_MAX_CODE) ? DIV_MAX_CODE
                                                             : prescale_division_select;

  logic divTick;
  logic divClk;

  glitchless_divider uDivider (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .divSelect (effDiv),
    .divTick   (divTick),
    .divClk    (divClk)
  );

  // ==========================================================
  // Clock output and divided tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      systemClockTick   <= 1'b0;
      clock_output_pin  <= 1'b0;
      clockOutputPinEnN <= 1'b1;
    end else begin
      systemClockTick <= divTick && state_reg == ST_RUN;
      if (clkOutFuse_reg) begin
        clock_output_pin  <= divClk;
        clockOutputPinEnN <= 1'b0;
      end else begin
        clock_output_pin  <= portPinOut;
        clockOutputPinEnN <= portPinOutEnN;
      end
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rdValid) begin
      case (haddr[11:0])
        TRIM_ADDR:        hrdata <= {24'h00_0000, rc_oscillator_trim};
        PRESCALE_ADDR:    hrdata <= {24'h00_0000, prescale_change_enable, 3'h0, prescale_division_select};
        ASYNC_TIMER_ADDR: hrdata <= {27'h000_0000, timer_external_clock_select, 4'h0};
        STATUS_ADDR:      hrdata <= {24'h00_0000, coreRunning, timerOscEnable, sutFuse_reg, srcFuse_reg};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : clock_source_trim_prescaler
`default_nettype wire

// >>> tb/clock_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_checker
  import clock_ctrl_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        clock_output_fuse,
  input wire logic        portPinOutEnN,
  input wire logic        wakeRequest,
  input wire logic [7:0]  rc_oscillator_trim,
  input wire logic        sel128kOsc,
  input wire logic        selExternalClock,
  input wire logic        timerOscEnable,
  input wire logic        coreRunning,
  input wire logic        systemClockTick,
  input wire logic        clockOutputPinEnN
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Marks the data phase of a trim write
  logic trimWr_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) trimWr_reg <= 1'b0;
    else if (hready) trimWr_reg <= hsel && htrans[1] && hwrite && haddr[11:0] == TRIM_ADDR;
  end
  // ==========================================================
  // Properties
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus response not ready or okay");
  property p_trim_load; trimWr_reg && hready |=> rc_oscillator_trim == $past(hwdata[7:0]); endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim write lost");
  property p_trim_hold; $past(resetn) && $changed(rc_oscillator_trim) |-> $past(trimWr_reg); endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");
  property p_start; $rose(resetn) |-> !coreRunning [*8] ##1 !coreRunning [*6]; endproperty
  a_start: assert property (p_start) else $error("core started too early");
  property p_run_hold;
    coreRunning && !wakeRequest && !$past(wakeRequest) && !$past(wakeRequest, 2)
      && !$past(wakeRequest, 3) |=> coreRunning;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("core stopped");
  property p_src_excl; !(sel128kOsc && selExternalClock); endproperty
  a_src_excl: assert property (p_src_excl) else $error("two sources selected");
  property p_timer; timerOscEnable |-> !selExternalClock; endproperty
  a_timer: assert property (p_timer) else $error("timer oscillator with external clock");
  property p_clkout; clock_output_fuse && coreRunning |-> !clockOutputPinEnN; endproperty
  a_clkout: assert property (p_clkout) else $error("clock output not driven");
  property p_portpass;
    !clock_output_fuse && coreRunning && $stable(portPinOutEnN) |=> clockOutputPinEnN == $past(portPinOutEnN);
  endproperty
  a_portpass: assert property (p_portpass) else $error("port function not restored");
  // Main scenarios
  c_tick: cover property (systemClockTick);
  c_run: cover property ($rose(coreRunning));
  c_trim: cover property (trimWr_reg);
  c_wake: cover property ($fell(coreRunning));
endmodule : clock_ctrl_checker
bind clock_source_trim_prescaler clock_ctrl_checker u_clock_ctrl_checker (.clk_sys, .resetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .clock_output_fuse, .portPinOutEnN, .wakeRequest,
  .rc_oscillator_trim, .sel128kOsc, .selExternalClock, .timerOscEnable, .coreRunning, .systemClockTick,
  .clockOutputPinEnN);
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clock_ctrl_pkg::*;
  localparam logic [7:0] F_TRIM = 8'h5a;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic   hready;
  logic [3:0]  srcF = 4'h3;
  logic [1:0]  sutF = 2'h0;
  logic        rpdF = 1'b0, outF = 1'b1, div8F = 1'b0, pinEnN = 1'b1, timerReq = 1'b0, wakeReq = 1'b0;
  logic [31:0] hrdata;
  logic [7:0]  trim;
  logic        hreadyout, hresp, sel128k, selExt, timerEn, extSel, coreRunning, sysTick, clkPin, clkPinEnN;
  int          badCount = 0;
  int          samplesChecked = 0;
  int          n, c;
  logic [31:0] expQ[$];
  logic        rdPend = 1'b0;
  logic [31:0] rnd = 32'h56c8_78d8;
  logic [3:0]  srcT[7] = '{4'h3, 4'h3, 4'h3, 4'h0, 4'h0, 4'h3, 4'h2};
  logic [1:0]  sutT[7] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0};
  int          extraT[7] = '{0, 20, 40, 30, 50, 30, 0};

  // ==========================================================
  // Clock and device
  always #2.5 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  clock_source_trim_prescaler #(.FACTORY_TRIM(F_TRIM), .DELAY_4_CNT(20), .DELAY_4P1_CNT(30),
    .DELAY_64_CNT(40), .DELAY_65_CNT(50)) u_clock_source_trim_prescaler (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .clock_source_fuses(srcF), .startup_time_fuses(sutF), .reset_pin_disable_fuse(rpdF),
    .clock_output_fuse(outF), .divide_by_eight_fuse(div8F), .portPinOut(rnd[3]), .portPinOutEnN(pinEnN),
    .timerOscRequest(timerReq), .wakeRequest(wakeReq), .rc_oscillator_trim(trim), .sel128kOsc(sel128k),
    .selExternalClock(selExt), .timerOscEnable(timerEn), .timer_external_clock_select(extSel),
    .coreRunning(coreRunning), .systemClockTick(sysTick), .clock_output_pin(clkPin),
    .clockOutputPinEnN(clkPinEnN));

  // ==========================================================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : printVerdict
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    samplesChecked++;
    if (s !== e) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1) begin
      badCount++;
      printVerdict();
    end
  endtask : rdy
  // Single word transfer; for a read, d is the expected data
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    if (!w) expQ.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
  endtask : xfer
  // Cycles to the next divided tick, and clock pin changes meanwhile
  task automatic tick(output int t, output int ch);
    logic p;
    t = 0;
    ch = 0;
    p = clkPin;
    do begin
      @(posedge clk_sys);
      t++;
      if (clkPin !== p) ch++;
      p = clkPin;
    end while (sysTick !== 1'b1 && t < 800);
    if (t >= 800) begin
      badCount++;
      printVerdict();
    end
  endtask : tick
  // Reset with one fuse set, then count cycles to core start
  task automatic startRow(input int i, output int t);
    @(posedge clk_sys);
    resetn <= 1'b0;
    srcF <= srcT[i];
    sutF <= sutT[i];
    rpdF <= (i == 5);
    outF <= ~i[0];
    div8F <= i[0];
    timerReq <= (srcT[i] != 4'h3);
    pinEnN <= rnd[0];
    rnd <= lfsr(rnd);
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (coreRunning !== 1'b1 && t < 400);
  endtask : startRow

  // ==========================================================
  // Read data monitor against the queue of expectations
  always @(posedge clk_sys) begin
    if (rdPend && hreadyout && expQ.size() > 0) cmp("hrdata", expQ.pop_front(), hrdata);
    if (!resetn) rdPend <= 1'b0;
    else if (hreadyout) rdPend <= hsel && htrans[1] && !hwrite;
  end

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 7; i++) begin
      startRow(i, n);
      // Two synchroniser edges, fuse capture, sequencer entry, output flop and sampling add six edges
      cmp("startup", BASE_DELAY_CK + 6 + extraT[i], n);
      cmp("source", {sel128k, selExt, timerEn}, {srcT[i] == 4'h3, srcT[i] == 4'h0, srcT[i] == 4'h2});
      cmp("pin enable", outF ? 1'b0 : pinEnN, clkPinEnN);
      xfer(TRIM_ADDR, 1'b0, F_TRIM);
      xfer(STATUS_ADDR, 1'b0, {24'h0, 1'b1, srcT[i] == 4'h2, sutT[i], srcT[i]});
      xfer(PRESCALE_ADDR, 1'b0, i[0] ? 32'h3 : 32'h0);
      xfer(TRIM_ADDR, 1'b1, rnd[7:0]);
      xfer(TRIM_ADDR, 1'b0, rnd[7:0]);
      $display("test row %0d done", i);
    end
    xfer(PRESCALE_ADDR, 1'b1, 32'h80);
    xfer(PRESCALE_ADDR, 1'b1, 32'h05);
    xfer(PRESCALE_ADDR, 1'b0, 32'h05);
    xfer(PRESCALE_ADDR, 1'b1, 32'h02);
    xfer(PRESCALE_ADDR, 1'b1, 32'h81);
    xfer(PRESCALE_ADDR, 1'b1, 32'h01);
    xfer(PRESCALE_ADDR, 1'b0, 32'h05);
    xfer(PRESCALE_ADDR, 1'b1, 32'h80);
    repeat (6) @(posedge clk_sys);
    xfer(PRESCALE_ADDR, 1'b1, 32'h01);
    xfer(PRESCALE_ADDR, 1'b0, 32'h05);
    $display("test unlock done");
    for (int d = 0; d < 10; d++) begin
      xfer(PRESCALE_ADDR, 1'b1, 32'h80);
      xfer(PRESCALE_ADDR, 1'b1, d);
      repeat (4) tick(n, c);
      cmp("period", 1 << (d > 8 ? 8 : d), n);
      if (d > 0) cmp("clock pin changes", 2, c);
    end
    $display("test division done");
    xfer(ASYNC_TIMER_ADDR, 1'b1, 32'h10);
    xfer(ASYNC_TIMER_ADDR, 1'b0, 32'h10);
    cmp("timer ext select", 1'b1, extSel);
    xfer(12'h010, 1'b1, 32'hff);
    xfer(12'h010, 1'b0, 32'h0);
    $display("test registers done");
    // Wake pulse: core pauses for the short wake delay
    wakeReq <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
      wakeReq <= 1'b0;
    end while (coreRunning !== 1'b0 && c < 20);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (coreRunning !== 1'b1 && n < 40);
    cmp("wake delay", WAKE_DELAY_CK, n);
    $display("test wake done");
    printVerdict();
  end
endmodule : tb
`default_nettype wire
